// ---- inc/core_cfg.svh ----
`ifndef CORE_CFG_SVH
`define CORE_CFG_SVH

`define IDX_PC 4'h0
`define IDX_SP 4'h1
`define IDX_SR 4'h2
`define IDX_CONST 4'h3

`define SR_C 0
`define SR_Z 1
`define SR_N 2
`define SR_GIE 3
`define SR_CPUOFF 4
`define SR_OSCOFF 5
`define SR_SCG0 6
`define SR_SCG1 7
`define SR_V 8
`define SR_SHDN 9
`define SR_WAKE_CLEAR 16'h00f8

`define WORD_STEP 16'h0002
`define RESET_WORD 16'h0000
`define CONST_ZERO 16'h0000
`define CONST_ONE 16'h0001
`define CONST_TWO 16'h0002
`define CONST_ALL 16'hffff

`endif

// ---- inc/core_pkg.sv ----
package core_pkg;

    typedef enum logic [2:0] {
        SRC_REG = 3'h0,
        SRC_INDEXED = 3'h1,
        SRC_SYMBOLIC = 3'h2,
        SRC_ABSOLUTE = 3'h3,
        SRC_INDIRECT = 3'h4,
        SRC_AUTOINC = 3'h5,
        SRC_IMMEDIATE = 3'h6
    } src_mode_t;

    typedef enum logic [1:0] {
        DST_REG = 2'h0,
        DST_INDEXED = 2'h1,
        DST_SYMBOLIC = 2'h2,
        DST_ABSOLUTE = 2'h3
    } dst_mode_t;

    typedef enum logic [3:0] {
        OP_MOV = 4'h0,
        OP_ADD = 4'h1,
        OP_SUB = 4'h2,
        OP_AND = 4'h3,
        OP_XOR = 4'h4,
        OP_BIS = 4'h5,
        OP_BIC = 4'h6,
        OP_CMP = 4'h7,
        OP_RETI = 4'h8
    } op_t;

    typedef enum logic [2:0] {
        ST_EXEC = 3'h0,
        ST_SRC = 3'h1,
        ST_DST_RD = 3'h3,
        ST_DST_WR = 3'h2,
        ST_PUSH_PC = 3'h6,
        ST_PUSH_SR = 3'h7,
        ST_POP_SR = 3'h5,
        ST_POP_PC = 3'h4
    } state_t;

    typedef enum logic [2:0] {
        ACTIVE = 3'h0,
        PROCESSOR_OFF_SLEEP = 3'h1,
        STANDBY_SLEEP = 3'h2,
        DEEP_OFF_SLEEP = 3'h3,
        TIMEKEEPING_ONLY_SHUTDOWN = 3'h4,
        FULL_SHUTDOWN = 3'h5
    } power_mode_t;

    typedef struct packed {
        op_t op;
        logic [3:0] src_reg;
        src_mode_t src_mode;
        logic [3:0] dst_reg;
        dst_mode_t dst_mode;
        logic [15:0] src_ext;
        logic [15:0] dst_ext;
    } instr_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic rd;
        logic wr;
    } bus_req_t;

endpackage

// ---- rtl/cpu_core_regs.sv ----
`timescale 1ns/1ps
`include "core_cfg.svh"

// How it works
// - sixteen registers of sixteen bits each
// - r0 pc, r1 sp, r2 sr, r3 constants
// - registers four to fifteen are general purpose
// - register to register finishes in one cycle
// - seven source modes, four destination modes
// - operations are register ops plus addressing
// - peripherals reached as operands over bus
// - low-power modes entered only by software
// - interrupt wakes sleep, return resumes sleep
// - shutdown modes remove core supply
module cpu_core_regs (
    input wire logic clk,
    input wire logic srst,
    input wire core_pkg::instr_t instr,
    input wire logic instr_valid,
    output logic instr_ready,
    input wire logic irq_req,
    input wire logic [15:0] irq_vector,
    input wire logic [15:0] bus_rdata,
    output core_pkg::bus_req_t bus_req,
    output logic done,
    output core_pkg::power_mode_t sleep_mode,
    output logic core_supply_en,
    output logic cpu_clk_en
);

    logic [15:0] regs [16];
    core_pkg::state_t state;
    core_pkg::instr_t cur;
    core_pkg::instr_t in;
    logic [15:0] src_val;
    logic [15:0] direct;
    logic [15:0] opnd_s;
    logic [15:0] opnd_d;
    logic [16:0] alu_res;
    logic [15:0] sr_flags;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [15:0] sr;
    logic take;
    logic irq_take;
    logic shut_req;
    logic reg_finish;

    function automatic logic src_mem(core_pkg::instr_t i);
        src_mem = i.src_reg != `IDX_CONST && i.src_mode != core_pkg::SRC_REG
            && i.src_mode != core_pkg::SRC_IMMEDIATE;
    endfunction

    function automatic logic [15:0] const_value(core_pkg::src_mode_t m);
        case (m)
            core_pkg::SRC_INDEXED: const_value = `CONST_ONE;
            core_pkg::SRC_INDIRECT: const_value = `CONST_TWO;
            core_pkg::SRC_AUTOINC: const_value = `CONST_ALL;
            default: const_value = `CONST_ZERO;
        endcase
    endfunction

    function automatic logic [15:0] eff_addr(logic [2:0] mode, logic [15:0] base,
                                             logic [15:0] ext, logic [15:0] pcv);
        case (mode)
            3'h1: eff_addr = base + ext;
            3'h2: eff_addr = pcv + ext;
            3'h3: eff_addr = ext;
            default: eff_addr = base;
        endcase
    endfunction

    function automatic logic writes(core_pkg::op_t op);
        writes = op != core_pkg::OP_CMP && op != core_pkg::OP_RETI;
    endfunction

    function automatic logic [16:0] alu(core_pkg::op_t op, logic [15:0] s, logic [15:0] d);
        case (op)
            core_pkg::OP_ADD: alu = {1'b0, d} + {1'b0, s};
            core_pkg::OP_SUB, core_pkg::OP_CMP: alu = {1'b0, d} + {1'b0, ~s} + 17'h1;
            core_pkg::OP_AND: alu = {1'b0, d & s};
            core_pkg::OP_XOR: alu = {1'b0, d ^ s};
            core_pkg::OP_BIS: alu = {1'b0, d | s};
            core_pkg::OP_BIC: alu = {1'b0, d & ~s};
            default: alu = {1'b0, s};
        endcase
    endfunction

    function automatic logic [15:0] set_flags(logic [15:0] f, core_pkg::op_t op,
                                              logic [16:0] r, logic [15:0] s, logic [15:0] d);
        logic [15:0] n;
        n = f;
        if (op inside {core_pkg::OP_ADD, core_pkg::OP_SUB, core_pkg::OP_CMP,
                       core_pkg::OP_AND, core_pkg::OP_XOR}) begin
            n[`SR_Z] = r[15:0] == 16'h0000;
            n[`SR_N] = r[15];
            if (op == core_pkg::OP_ADD) begin
                n[`SR_C] = r[16];
                n[`SR_V] = s[15] == d[15] && r[15] != d[15];
            end else if (op == core_pkg::OP_AND || op == core_pkg::OP_XOR) begin
                n[`SR_C] = r[15:0] != 16'h0000;
                n[`SR_V] = 1'b0;
            end else begin
                n[`SR_C] = r[16];
                n[`SR_V] = s[15] != d[15] && r[15] != d[15];
            end
        end
        set_flags = n;
    endfunction

    assign pc = regs[`IDX_PC];
    assign sp = regs[`IDX_SP];
    assign sr = regs[`IDX_SR];

    always_comb begin
        in = (state == core_pkg::ST_EXEC) ? instr : cur;
        if (in.src_reg == `IDX_CONST)
            direct = const_value(in.src_mode);
        else if (in.src_mode == core_pkg::SRC_IMMEDIATE)
            direct = in.src_ext;
        else
            direct = regs[in.src_reg];
        if (state == core_pkg::ST_SRC)
            opnd_s = bus_rdata;
        else if (state == core_pkg::ST_EXEC)
            opnd_s = direct;
        else
            opnd_s = src_val;
        opnd_d = (state == core_pkg::ST_DST_RD) ? bus_rdata : regs[in.dst_reg];
        alu_res = alu(in.op, opnd_s, opnd_d);
        sr_flags = set_flags(sr, in.op, alu_res, opnd_s, opnd_d);
    end

    assign take = state == core_pkg::ST_EXEC && instr_valid && instr_ready;
    assign shut_req = sr[`SR_SHDN] && sr[`SR_CPUOFF] && sr[`SR_SCG1];
    assign irq_take = state == core_pkg::ST_EXEC && core_supply_en && irq_req
        && sr[`SR_GIE] && !take && !shut_req;
    assign reg_finish = (take && instr.op != core_pkg::OP_RETI && !src_mem(instr)
        && instr.dst_mode == core_pkg::DST_REG)
        || (state == core_pkg::ST_SRC && cur.dst_mode == core_pkg::DST_REG);

    always_ff @(posedge clk) begin
        if (srst) begin
            state <= core_pkg::ST_EXEC;
            for (int k = 0; k < 16; k++)
                regs[k] <= `RESET_WORD;
            cur <= '0;
            src_val <= `RESET_WORD;
            bus_req <= '0;
            done <= 1'b0;
            instr_ready <= 1'b1;
        end else if (core_supply_en) begin
            bus_req.rd <= 1'b0;
            bus_req.wr <= 1'b0;
            done <= 1'b0;
            if (state == core_pkg::ST_SRC && cur.src_mode == core_pkg::SRC_AUTOINC)
                regs[cur.src_reg] <= regs[cur.src_reg] + `WORD_STEP;
            if (reg_finish) begin
                regs[`IDX_SR] <= sr_flags;
                if (writes(in.op) && in.dst_reg != `IDX_CONST)
                    regs[in.dst_reg] <= alu_res[15:0];
                if (!(writes(in.op) && in.dst_reg == `IDX_PC))
                    regs[`IDX_PC] <= pc + `WORD_STEP;
                state <= core_pkg::ST_EXEC;
                done <= 1'b1;
                // software alone sets the sleep bits
                if (writes(in.op) && in.dst_reg == `IDX_SR)
                    instr_ready <= !alu_res[`SR_CPUOFF];
                else
                    instr_ready <= !sr[`SR_CPUOFF];
            end
            unique case (state)
                core_pkg::ST_EXEC: begin
                    if (irq_take) begin
                        regs[`IDX_SP] <= sp - `WORD_STEP;
                        bus_req <= '{addr: sp - `WORD_STEP, wdata: pc, rd: 1'b0, wr: 1'b1};
                        state <= core_pkg::ST_PUSH_PC;
                        instr_ready <= 1'b0;
                    end else if (take && !reg_finish) begin
                        cur <= instr;
                        instr_ready <= 1'b0;
                        src_val <= opnd_s;
                        if (instr.op == core_pkg::OP_RETI) begin
                            bus_req <= '{addr: sp, wdata: `RESET_WORD, rd: 1'b1, wr: 1'b0};
                            state <= core_pkg::ST_POP_SR;
                        end else if (src_mem(instr)) begin
                            bus_req <= '{addr: eff_addr(instr.src_mode, direct,
                                instr.src_ext, pc), wdata: `RESET_WORD,
                                rd: 1'b1, wr: 1'b0};
                            state <= core_pkg::ST_SRC;
                        end else begin
                            bus_req <= '{addr: eff_addr({1'b0, instr.dst_mode},
                                regs[instr.dst_reg], instr.dst_ext, pc), wdata: opnd_s,
                                rd: instr.op != core_pkg::OP_MOV,
                                wr: instr.op == core_pkg::OP_MOV};
                            state <= (instr.op == core_pkg::OP_MOV) ?
                                core_pkg::ST_DST_WR : core_pkg::ST_DST_RD;
                        end
                    end
                end
                core_pkg::ST_SRC: begin
                    if (cur.dst_mode != core_pkg::DST_REG) begin
                        src_val <= bus_rdata;
                        bus_req <= '{addr: eff_addr({1'b0, cur.dst_mode},
                            regs[cur.dst_reg], cur.dst_ext, pc), wdata: bus_rdata,
                            rd: cur.op != core_pkg::OP_MOV,
                            wr: cur.op == core_pkg::OP_MOV};
                        state <= (cur.op == core_pkg::OP_MOV) ?
                            core_pkg::ST_DST_WR : core_pkg::ST_DST_RD;
                    end
                end
                core_pkg::ST_DST_RD: begin
                    regs[`IDX_SR] <= sr_flags;
                    bus_req <= '{addr: bus_req.addr, wdata: alu_res[15:0], rd: 1'b0,
                        wr: writes(cur.op)};
                    state <= core_pkg::ST_DST_WR;
                end
                core_pkg::ST_DST_WR: begin
                    regs[`IDX_PC] <= pc + `WORD_STEP;
                    done <= 1'b1;
                    state <= core_pkg::ST_EXEC;
                    instr_ready <= !sr[`SR_CPUOFF];
                end
                core_pkg::ST_PUSH_PC: begin
                    regs[`IDX_SP] <= sp - `WORD_STEP;
                    bus_req <= '{addr: sp - `WORD_STEP, wdata: sr, rd: 1'b0, wr: 1'b1};
                    state <= core_pkg::ST_PUSH_SR;
                end
                core_pkg::ST_PUSH_SR: begin
                    regs[`IDX_SR] <= sr & ~`SR_WAKE_CLEAR;
                    regs[`IDX_PC] <= irq_vector;
                    state <= core_pkg::ST_EXEC;
                    instr_ready <= 1'b1;
                end
                core_pkg::ST_POP_SR: begin
                    regs[`IDX_SR] <= bus_rdata;
                    regs[`IDX_SP] <= sp + `WORD_STEP;
                    bus_req <= '{addr: sp + `WORD_STEP, wdata: `RESET_WORD,
                        rd: 1'b1, wr: 1'b0};
                    state <= core_pkg::ST_POP_PC;
                end
                core_pkg::ST_POP_PC: begin
                    regs[`IDX_PC] <= bus_rdata;
                    regs[`IDX_SP] <= sp + `WORD_STEP;
                    done <= 1'b1;
                    state <= core_pkg::ST_EXEC;
                    instr_ready <= !sr[`SR_CPUOFF];
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            sleep_mode <= core_pkg::ACTIVE;
            core_supply_en <= 1'b1;
            cpu_clk_en <= 1'b1;
        end else begin
            cpu_clk_en <= !sr[`SR_CPUOFF];
            if (shut_req)
                core_supply_en <= 1'b0;
            if (!sr[`SR_CPUOFF])
                sleep_mode <= core_pkg::ACTIVE;
            else if (shut_req && sr[`SR_OSCOFF])
                sleep_mode <= core_pkg::FULL_SHUTDOWN;
            else if (shut_req)
                sleep_mode <= core_pkg::TIMEKEEPING_ONLY_SHUTDOWN;
            else if (sr[`SR_SCG1] && sr[`SR_OSCOFF])
                sleep_mode <= core_pkg::DEEP_OFF_SLEEP;
            else if (sr[`SR_SCG1])
                sleep_mode <= core_pkg::STANDBY_SLEEP;
            else
                sleep_mode <= core_pkg::PROCESSOR_OFF_SLEEP;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    reg_reg_single_a: assert property (
        reg_finish && state == core_pkg::ST_EXEC |=> done && state == core_pkg::ST_EXEC
    ) else $error("register op did not finish in one cycle");

    const_reg_a: assert property (
        regs[`IDX_CONST] == `RESET_WORD
    ) else $error("constant register was written");

    pc_advance_a: assert property (
        reg_finish && state == core_pkg::ST_EXEC && instr.dst_reg != `IDX_PC
        |=> pc == $past(pc) + `WORD_STEP
    ) else $error("pc did not step by one word");

    asleep_stalls_a: assert property (
        instr_ready |-> !sr[`SR_CPUOFF]
    ) else $error("instruction accepted while processor off");

    irq_push_a: assert property (
        irq_take |=> bus_req.wr && bus_req.addr == $past(sp) - `WORD_STEP
        ##1 bus_req.wr && bus_req.wdata == $past(sr, 2)
        ##1 state == core_pkg::ST_EXEC && !sr[`SR_CPUOFF] && pc == $past(irq_vector)
    ) else $error("interrupt entry sequence wrong");

    sr_restore_a: assert property (
        state == core_pkg::ST_POP_SR |=> sr == $past(bus_rdata) ##1 done
    ) else $error("status not restored on return");

    supply_off_a: assert property (
        shut_req |=> !core_supply_en ##1 !core_supply_en
    ) else $error("shutdown did not remove core supply");

    src_fetch_a: assert property (
        take && instr.op != core_pkg::OP_RETI && src_mem(instr)
        |=> state == core_pkg::ST_SRC && bus_req.rd && !bus_req.wr
    ) else $error("memory source not fetched over bus");

    mov_store_a: assert property (
        state == core_pkg::ST_DST_WR && cur.op == core_pkg::OP_MOV |-> bus_req.wr
    ) else $error("move to memory not written");

endmodule

// ---- sim/periph_model.sv ----
`timescale 1ns/1ps
module periph_model (
    input wire logic clk,
    input wire core_pkg::bus_req_t bus_req,
    output logic [15:0] bus_rdata
);
    logic [15:0] mem [0:255];
    logic [15:0] last = 16'h0000;

    initial begin
        for (int k = 0; k < 256; k++) begin
            mem[k] = {8'h5a, k[7:0]};
        end
    end

    // any access size is a whole word, reads answer at once
    always @(posedge clk) begin
        if (bus_req.wr) begin
            mem[bus_req.addr[8:1]] <= bus_req.wdata;
        end
        if (bus_req.rd) begin
            last <= bus_rdata;
        end
    end

    // idle bus shows no stale word
    assign bus_rdata = bus_req.rd ? mem[bus_req.addr[8:1]] : ~last;
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    typedef struct {
        core_pkg::op_t op;
        logic [15:0] a;
        logic [15:0] b;
        logic [15:0] exp;
    } row_t;
    logic clk;
    logic srst;
    core_pkg::instr_t instr;
    logic instr_valid;
    logic instr_ready;
    logic irq_req;
    logic [15:0] irq_vector;
    logic [15:0] bus_rdata;
    core_pkg::bus_req_t bus_req;
    logic done;
    core_pkg::power_mode_t sleep_mode;
    logic core_supply_en;
    logic cpu_clk_en;
    int fail_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int n;
    logic [31:0] wq[$];
    logic [15:0] last_rd;
    row_t rows[8];
    logic [15:0] sa[4] = '{16'h0014, 16'h0030, 16'h0010, 16'h0010};
    logic [15:0] cvals[4] = '{16'h0000, 16'h0001, 16'h0002, 16'hffff};
    logic [15:0] bits[5] = '{16'h0018, 16'h0098, 16'h00b8, 16'h0298, 16'h02b8};
    core_pkg::power_mode_t pm[5] = '{core_pkg::PROCESSOR_OFF_SLEEP, core_pkg::STANDBY_SLEEP,
        core_pkg::DEEP_OFF_SLEEP, core_pkg::TIMEKEEPING_ONLY_SHUTDOWN, core_pkg::FULL_SHUTDOWN};
    core_pkg::src_mode_t sm[4] = '{core_pkg::SRC_INDEXED, core_pkg::SRC_ABSOLUTE,
        core_pkg::SRC_INDIRECT, core_pkg::SRC_AUTOINC};
    core_pkg::src_mode_t cm[4] = '{core_pkg::SRC_REG, core_pkg::SRC_INDEXED,
        core_pkg::SRC_INDIRECT, core_pkg::SRC_AUTOINC};

    cpu_core_regs cpu_core_regs_i (.clk(clk), .srst(srst), .instr(instr),
        .instr_valid(instr_valid), .instr_ready(instr_ready), .irq_req(irq_req),
        .irq_vector(irq_vector), .bus_rdata(bus_rdata), .bus_req(bus_req), .done(done),
        .sleep_mode(sleep_mode), .core_supply_en(core_supply_en), .cpu_clk_en(cpu_clk_en));
    periph_model periph_model_i (.clk(clk), .bus_req(bus_req), .bus_rdata(bus_rdata));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (bus_req.wr === 1'b1) wq.push_back({bus_req.addr, bus_req.wdata});
        if (bus_req.rd === 1'b1) last_rd <= bus_req.addr;
        if (cycles == 20000) begin
            fail_count++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (fail_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h got %h", name, e, g);
        end
    endtask

    task automatic chk_mode(input core_pkg::power_mode_t e);
        comparisons++;
        if (sleep_mode !== e) begin
            fail_count++;
            $display("[ERR] sleep_mode expected %h got %h", e, sleep_mode);
        end
    endtask

    function automatic core_pkg::instr_t mk(core_pkg::op_t op, logic [3:0] sr,
        core_pkg::src_mode_t smd, logic [3:0] dr, core_pkg::dst_mode_t dmd,
        logic [15:0] se, logic [15:0] de);
        return '{op, sr, smd, dr, dmd, se, de};
    endfunction

    function automatic core_pkg::instr_t imm(core_pkg::op_t op, logic [15:0] v, logic [3:0] r);
        return mk(op, 4'h0, core_pkg::SRC_IMMEDIATE, r, core_pkg::DST_REG, v, 16'h0000);
    endfunction

    function automatic logic [15:0] mval(input logic [15:0] a);
        return {8'h5a, a[8:1]};
    endfunction

    task automatic issue(input core_pkg::instr_t i, input int lat);
        int c;
        instr <= i;
        instr_valid <= 1'b1;
        c = 0;
        do begin @(posedge clk); c++; end while (instr_ready !== 1'b1 && c < 50);
        instr_valid <= 1'b0;
        c = 0;
        do begin @(posedge clk); c++; end while (done !== 1'b1 && c < 50);
        chk("latency", lat[15:0], c[15:0]);
    endtask

    task automatic store(input logic [3:0] r, input logic [15:0] e);
        wq.delete();
        issue(mk(core_pkg::OP_MOV, r, core_pkg::SRC_REG, 4'h2, core_pkg::DST_ABSOLUTE,
            16'h0000, 16'h0040), 2);
        chk("store addr", 16'h0040, wq[$][31:16]);
        chk("store data", e, wq[$][15:0]);
    endtask

    task automatic do_reset();
        srst <= 1'b1;
        irq_req <= 1'b0;
        instr_valid <= 1'b0;
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        chk("reset ready", 16'h0001, {15'h0, instr_ready});
        chk("reset supply", 16'h0001, {15'h0, core_supply_en});
        chk("reset clk_en", 16'h0001, {15'h0, cpu_clk_en});
        chk("reset done", 16'h0000, {15'h0, done});
        chk_mode(core_pkg::ACTIVE);
    endtask

    initial begin
        srst = 1'b1;
        instr = '0;
        instr_valid = 1'b0;
        irq_req = 1'b0;
        irq_vector = 16'h0200;
        rows = '{'{core_pkg::OP_MOV, 16'h1234, 16'hbeef, 16'hbeef},
            '{core_pkg::OP_ADD, 16'h1234, 16'h0101, 16'h1335},
            '{core_pkg::OP_ADD, 16'hffff, 16'h0001, 16'h0000},
            '{core_pkg::OP_SUB, 16'h1234, 16'h0034, 16'h1200},
            '{core_pkg::OP_AND, 16'hff0f, 16'h0ff0, 16'h0f00},
            '{core_pkg::OP_XOR, 16'hff00, 16'h0ff0, 16'hf0f0},
            '{core_pkg::OP_BIS, 16'h1200, 16'h0034, 16'h1234},
            '{core_pkg::OP_BIC, 16'h1234, 16'h0034, 16'h1200}};
        do_reset();
        foreach (rows[k]) begin
            issue(imm(core_pkg::OP_MOV, rows[k].a, 4'h4), 1);
            issue(imm(rows[k].op, rows[k].b, 4'h4), 1);
            store(4'h4, rows[k].exp);
        end
        for (int k = 4; k < 16; k++)
            issue(imm(core_pkg::OP_MOV, 16'h0a00 + k[15:0], k[3:0]), 1);
        for (int k = 4; k < 16; k++) store(k[3:0], 16'h0a00 + k[15:0]);
        for (int k = 0; k < 4; k++) begin
            wq.delete();
            issue(mk(core_pkg::OP_MOV, 4'h3, cm[k], 4'h2, core_pkg::DST_ABSOLUTE, 16'h0000,
                16'h0040), 2);
            chk("constant", cvals[k], wq[$][15:0]);
        end
        issue(imm(core_pkg::OP_MOV, 16'h0010, 4'h5), 1);
        for (int k = 0; k < 4; k++) begin
            issue(mk(core_pkg::OP_MOV, 4'h5, sm[k], 4'h6, core_pkg::DST_REG,
                (k == 0) ? 16'h0004 : 16'h0030, 16'h0000), 2);
            chk("read addr", sa[k], last_rd);
            store(4'h6, mval(sa[k]));
        end
        store(4'h5, 16'h0012);
        issue(imm(core_pkg::OP_MOV, 16'h0100, 4'h0), 1);
        issue(mk(core_pkg::OP_MOV, 4'h0, core_pkg::SRC_SYMBOLIC, 4'h7, core_pkg::DST_REG,
            16'h0010, 16'h0000), 2);
        chk("symbolic src", 16'h0110, last_rd);
        wq.delete();
        issue(mk(core_pkg::OP_MOV, 4'h7, core_pkg::SRC_REG, 4'h0, core_pkg::DST_SYMBOLIC,
            16'h0000, 16'h0020), 2);
        chk("symbolic dst", 16'h0122, wq[$][31:16]);
        chk("symbolic data", mval(16'h0110), wq[$][15:0]);
        wq.delete();
        issue(mk(core_pkg::OP_MOV, 4'h6, core_pkg::SRC_REG, 4'h5, core_pkg::DST_INDEXED,
            16'h0000, 16'h0004), 2);
        chk("indexed dst", 16'h0016, wq[$][31:16]);
        issue(mk(core_pkg::OP_ADD, 4'h2, core_pkg::SRC_IMMEDIATE, 4'h2, core_pkg::DST_ABSOLUTE,
            16'h0001, 16'h0030), 3);
        chk("mem add", mval(16'h0030) + 16'h0001, wq[$][15:0]);
        issue(mk(core_pkg::OP_ADD, 4'h2, core_pkg::SRC_ABSOLUTE, 4'h2, core_pkg::DST_ABSOLUTE,
            16'h0030, 16'h0032), 4);
        chk("mem to mem", 16'hb432, wq[$][15:0]);
        wq.delete();
        issue(mk(core_pkg::OP_CMP, 4'h2, core_pkg::SRC_IMMEDIATE, 4'h2, core_pkg::DST_ABSOLUTE,
            16'h0001, 16'h0030), 3);
        chk("cmp writes", 16'h0000, 16'(wq.size()));
        store(4'h2, 16'h0001);
        instr <= imm(core_pkg::OP_MOV, 16'h0007, 4'h4);
        instr_valid <= 1'b1;
        @(posedge clk);
        instr <= imm(core_pkg::OP_ADD, 16'h0001, 4'h4);
        @(posedge clk);
        chk("b2b ready", 16'h0001, {15'h0, instr_ready});
        chk("b2b done", 16'h0001, {15'h0, done});
        instr_valid <= 1'b0;
        @(posedge clk);
        store(4'h4, 16'h0008);
        for (int k = 0; k < 5; k++) begin
            do_reset();
            issue(imm(core_pkg::OP_MOV, 16'h0080, 4'h1), 1);
            issue(imm(core_pkg::OP_MOV, 16'h0100, 4'h0), 1);
            issue(imm(core_pkg::OP_BIS, bits[k], 4'h2), 1);
            repeat (2) @(posedge clk);
            chk("sleep ready", 16'h0000, {15'h0, instr_ready});
            chk("sleep clk_en", 16'h0000, {15'h0, cpu_clk_en});
            chk_mode(pm[k]);
            chk("supply", (k < 3) ? 16'h0001 : 16'h0000, {15'h0, core_supply_en});
            wq.delete();
            irq_req <= 1'b1;
            n = 0;
            while (wq.size() < 2 && n < 20) begin
                @(posedge clk);
                irq_req <= 1'b0;
                n++;
            end
            repeat (3) @(posedge clk);
            if (k >= 3) begin
                chk("shutdown writes", 16'h0000, wq.size());
                chk("shutdown ready", 16'h0000, {15'h0, instr_ready});
                chk("shutdown supply", 16'h0000, {15'h0, core_supply_en});
            end else begin
                chk("pushed pc addr", 16'h007e, wq[0][31:16]);
                chk("pushed pc", 16'h0102, wq[0][15:0]);
                chk("pushed sr", bits[k], wq[1][15:0] & 16'h02f8);
                chk("awake ready", 16'h0001, {15'h0, instr_ready});
                chk_mode(core_pkg::ACTIVE);
                store(4'h0, 16'h0200);
                issue(mk(core_pkg::OP_RETI, 4'h0, core_pkg::SRC_REG, 4'h0, core_pkg::DST_REG,
                    16'h0000, 16'h0000), 3);
                repeat (2) @(posedge clk);
                chk("resleep ready", 16'h0000, {15'h0, instr_ready});
                chk_mode(pm[k]);
            end
        end
        do_reset();
        complete_run();
    end
endmodule
